// ===== src/p9afm_map.vh
// Register addresses, implemented-bit masks and reset values of the port 9 function mux
`ifndef P9AFM_MAP_VH
`define P9AFM_MAP_VH

// Byte addresses: full and low-byte view at the base, high-byte view at base + 1
`define P9AFM_MODE_ADDR      32'hFFFFF452
`define P9AFM_MODE_HI_ADDR   32'hFFFFF453
`define P9AFM_FUNC_ADDR      32'hFFFFF472
`define P9AFM_FUNC_HI_ADDR   32'hFFFFF473
`define P9AFM_EXT_ADDR       32'hFFFFF712
`define P9AFM_EXT_HI_ADDR    32'hFFFFF713

// Reset values
`define P9AFM_MODE_RESET     16'h0000
`define P9AFM_FUNC_RESET     16'h0000
`define P9AFM_EXT_RESET      16'h0000

// Device variants
`define P9AFM_VAR_SMALL      2'h0
`define P9AFM_VAR_MID        2'h1
`define P9AFM_VAR_LARGE      2'h2

// Implemented bits of mode and function control per variant
`define P9AFM_CTL_MASK_SMALL 16'hC0C3
`define P9AFM_CTL_MASK_MID   16'hC3C3
`define P9AFM_CTL_MASK_LARGE 16'hFFDF

// Implemented bits of the function extension per variant
`define P9AFM_EXT_MASK_SMALL 16'hC0C3
`define P9AFM_EXT_MASK_LARGE 16'hC0DF

// Access sizes
`define P9AFM_SIZE_BYTE      1'h0
`define P9AFM_SIZE_HALF      1'h1

`endif

// ===== src/p9afm_sync.v
// Three-stage pin input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module p9afm_sync #(
  parameter W     = 16,
  parameter RESET = 16'h0000
) (
  // Clock and reset
  input  wire         clock_i,
  input  wire         reset_n_i,
  // Asynchronous input and filtered result
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] mid_q;
  reg [W-1:0] late_q;

  // First stage is only read by the second, so no logic sees a metastable value
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= RESET[W-1:0];
      mid_q  <= RESET[W-1:0];
      late_q <= RESET[W-1:0];
      sync_o <= RESET[W-1:0];
    end else begin
      meta_q <= async_i;
      mid_q  <= meta_q;
      late_q <= mid_q;
      // Per bit: a single-cycle disagreement is treated as a glitch and dropped
      sync_o <= (mid_q & late_q) | (sync_o & (mid_q ^ late_q));
    end
  end

endmodule

// ===== src/p9afm_reg16.v
// Sixteen-bit control register with byte-lane and single-bit writes and fixed-zero bits
`timescale 1ns/1ps
module p9afm_reg16 #(
  parameter [15:0] MASK  = 16'hFFFF,
  parameter [15:0] RESET = 16'h0000
) (
  // Clock and reset
  input  wire        clock_i,
  input  wire        reset_n_i,
  // Write side
  input  wire        we_lo_i,
  input  wire        we_hi_i,
  input  wire        bit_mode_i,
  input  wire [3:0]  bit_sel_i,
  input  wire [15:0] data_i,
  // Stored value
  output wire [15:0] value_o
);

  reg  [15:0] value_q;
  reg  [15:0] value_d;
  reg  [15:0] lane_en;

  // Lane and bit enables, then masking so fixed-zero bits never store a one
  always @* begin
    lane_en = {{8{we_hi_i}}, {8{we_lo_i}}};
    if (bit_mode_i) begin
      lane_en = lane_en & (16'h0001 << bit_sel_i);
    end
    value_d = ((value_q & ~lane_en) | (data_i & lane_en)) & MASK;
  end

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_q <= RESET & MASK;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

endmodule

// ===== src/p9afm_mux.v
// Port 9 pin-function multiplexer: mode, function and extension registers plus pin routing
//
// Contract
// [RULE1] Mode bit 0 gives the pin to port I/O, 1 to the chosen alternate function.
// [RULE2] All three registers take 16-bit, byte and single-bit reads and writes.
// [RULE3] High-byte alias bits 0 to 7 map onto register bits 8 to 15.
// [RULE4] Software clears both function registers, then writes FFFFH to mode in one write.
// [RULE5] Function control resets to 0000H; full/low view at F472H, high at F473H.
// [RULE6] Function extension is read/write, resets to 0000H, has low and high byte views.
// [RULE7] Function control bits exist per variant; bit 5 always reads zero.
// [RULE8] Extension bits only at 0,1,6,7,14,15, plus 2 to 4 in largest variant.
// [RULE9] Pin 15 code 01 interrupt 6 in, 10 timer 50 capture, 11 timer 50 out.
// [RULE10] Pin 14 code 01 interrupt 5 in, 10 timer 51 capture, 11 timer 51 out.
// [RULE11] Pins 13 to 10: interrupt 4, serial 3 clock, serial 3 out, serial 3 in.
// [RULE12] Pins 9 and 8: serial 1 clock and serial 1 data out when control is 1.
// [RULE13] Pin 7 code 01 serial 1 in, 10 timer 20 capture, 11 timer 20 out.
// [RULE14] Pin 6 serves timer 21; pins 4,3,2 serve timers 31, 40, 41.
// [RULE15] Pin 6 code 10 timer 21 capture, 11 timer 21 out, others prohibited.
// [RULE16] Pins 4,3,2 code 01 capture input, 10 timer output; 00 and 11 prohibited.
// [RULE17] Pin 1 code 01 key return 7, 10 UART 1 receive, 11 I2C 2 clock.
// [RULE18] Pin 0 code 01 key return 6, 10 UART 1 transmit, 11 I2C 2 data.
// [RULE19] Writes to unimplemented bits are ignored and those bits read zero.
// [RULE20] Software never programs a prohibited code; the result is undefined.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "p9afm_map.vh"
module p9afm_mux #(
  parameter [1:0] VARIANT = `P9AFM_VAR_LARGE
) (
  // Clock and reset
  input  wire        clock_i,
  input  wire        reset_n_i,
  // Register port
  input  wire [31:0] bus_addr_i,
  input  wire [15:0] bus_wdata_i,
  input  wire        bus_write_i,
  input  wire        bus_read_i,
  input  wire        bus_size_i,
  input  wire        bus_bit_i,
  input  wire [2:0]  bus_bit_num_i,
  output reg  [15:0] bus_rdata_o,
  // Package pins
  input  wire [15:0] pin_in_i,
  output reg  [15:0] pin_out_o,
  output reg  [15:0] pin_oe_o,
  // Port data and direction logic
  input  wire [15:0] port_out_i,
  input  wire [15:0] port_oe_i,
  output wire [15:0] port_in_o,
  // Register views for the rest of the port
  output wire [15:0] port9_mode_control_o,
  // Peripheral inputs taken from pins
  output reg         external_interrupt_6_o,
  output reg         external_interrupt_5_o,
  output reg         external_interrupt_4_o,
  output reg         timer50_capture_in_o,
  output reg         timer51_capture_in_o,
  output reg         timer20_capture_in_o,
  output reg         timer21_capture_in_o,
  output reg         timer31_capture_in_o,
  output reg         timer40_capture_in_o,
  output reg         timer41_capture_in_o,
  output reg         serial3_data_in_o,
  output reg         serial3_clock_in_o,
  output reg         serial1_data_in_o,
  output reg         serial1_clock_in_o,
  output reg         key_return_6_o,
  output reg         key_return_7_o,
  output reg         uart1_receive_o,
  output reg         i2c2_clock_line_in_o,
  output reg         i2c2_data_line_in_o,
  // Peripheral outputs driven to pins
  input  wire        timer50_out_i,
  input  wire        timer51_out_i,
  input  wire        timer20_out_i,
  input  wire        timer21_out_i,
  input  wire        timer31_out_i,
  input  wire        timer40_out_i,
  input  wire        timer41_out_i,
  input  wire        serial3_clock_out_i,
  input  wire        serial3_clock_oe_i,
  input  wire        serial3_data_out_i,
  input  wire        serial1_clock_out_i,
  input  wire        serial1_clock_oe_i,
  input  wire        serial1_data_out_i,
  input  wire        uart1_transmit_i,
  input  wire        i2c2_clock_line_out_i,
  input  wire        i2c2_data_line_out_i
);

  // Implemented-bit masks chosen by the variant
  localparam [15:0] CTL_MASK = (VARIANT == `P9AFM_VAR_LARGE) ? `P9AFM_CTL_MASK_LARGE :
                               (VARIANT == `P9AFM_VAR_MID)   ? `P9AFM_CTL_MASK_MID :
                                                               `P9AFM_CTL_MASK_SMALL;
  localparam [15:0] EXT_MASK = (VARIANT == `P9AFM_VAR_LARGE) ? `P9AFM_EXT_MASK_LARGE :
                                                               `P9AFM_EXT_MASK_SMALL;

  // Register select indices
  localparam [1:0] SEL_MODE = 2'h0;
  localparam [1:0] SEL_FUNC = 2'h1;
  localparam [1:0] SEL_EXT  = 2'h2;
  localparam [1:0] SEL_NONE = 2'h3;

  // Decodes a byte address into register select, used by both read and write paths
  function [2:0] reg_decode;
    input [31:0] addr;
    begin
      case (addr)
        `P9AFM_MODE_ADDR:    reg_decode = {1'b0, SEL_MODE};
        `P9AFM_MODE_HI_ADDR: reg_decode = {1'b1, SEL_MODE};
        `P9AFM_FUNC_ADDR:    reg_decode = {1'b0, SEL_FUNC};
        `P9AFM_FUNC_HI_ADDR: reg_decode = {1'b1, SEL_FUNC};
        `P9AFM_EXT_ADDR:     reg_decode = {1'b0, SEL_EXT};
        `P9AFM_EXT_HI_ADDR:  reg_decode = {1'b1, SEL_EXT};
        default:             reg_decode = {1'b0, SEL_NONE};
      endcase
    end
  endfunction

  // Two-bit alternate code for one pin: extension bit over control bit
  function [1:0] pin_code;
    input [15:0] ext;
    input [15:0] ctl;
    input [3:0]  idx;
    begin
      pin_code = {ext[idx], ctl[idx]};
    end
  endfunction

  wire [2:0]  dec;
  wire        dec_hi;
  wire [1:0]  dec_sel;
  wire        half_ok;
  reg         we_lo;
  reg         we_hi;
  reg  [15:0] wr_data;
  wire [15:0] mode_q;
  wire [15:0] func_q;
  wire [15:0] ext_q;
  reg  [15:0] sel_val;
  wire [15:0] pin_s;

  assign dec     = reg_decode(bus_addr_i);
  assign dec_hi  = dec[2];
  assign dec_sel = dec[1:0];
  // A halfword access is only legal at the even base address
  assign half_ok = (bus_size_i == `P9AFM_SIZE_HALF) ? !dec_hi : 1'b1;

  // Lane enables: halfword writes take both lanes unless in bit mode, the high alias lands on bits 8 to 15
  always @* begin
    we_lo   = 1'b0;
    we_hi   = 1'b0;
    wr_data = 16'h0000;
    if (bus_write_i && (dec_sel != SEL_NONE) && half_ok) begin
      if (bus_size_i == `P9AFM_SIZE_HALF && !bus_bit_i) begin
        we_lo   = 1'b1;                                       // [RULE2]
        we_hi   = 1'b1;
        wr_data = bus_wdata_i;
      end else if (dec_hi) begin
        we_hi   = 1'b1;                                       // [RULE3]
        wr_data = {bus_wdata_i[7:0], 8'h00};
      end else begin
        we_lo   = 1'b1;
        wr_data = {8'h00, bus_wdata_i[7:0]};
      end
    end
  end

  // One register per select index; masks hold bit 5 and absent bits at zero [RULE5] [RULE6] [RULE7] [RULE8] [RULE19]
  wire [15:0] reg_val [0:2];
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_reg
      p9afm_reg16 #(
        .MASK  ((g == SEL_EXT) ? EXT_MASK : CTL_MASK),
        .RESET ((g == SEL_MODE) ? `P9AFM_MODE_RESET : (g == SEL_FUNC) ? `P9AFM_FUNC_RESET : `P9AFM_EXT_RESET)
      ) u_reg (
        .clock_i    (clock_i),
        .reset_n_i  (reset_n_i),
        .we_lo_i    (we_lo && {30'h0, dec_sel} == g),
        .we_hi_i    (we_hi && {30'h0, dec_sel} == g),
        .bit_mode_i (bus_bit_i),
        .bit_sel_i  ({dec_hi, bus_bit_num_i}),
        .data_i     (wr_data),
        .value_o    (reg_val[g])
      );
    end
  endgenerate
  assign mode_q = reg_val[SEL_MODE];
  assign func_q = reg_val[SEL_FUNC];
  assign ext_q  = reg_val[SEL_EXT];

  // Read data one cycle after the strobe; unmapped and misaligned reads give zero
  always @* begin
    case (dec_sel)
      SEL_MODE: sel_val = mode_q;
      SEL_FUNC: sel_val = func_q;
      SEL_EXT:  sel_val = ext_q;
      default:  sel_val = 16'h0000;
    endcase
  end

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_rdata_o <= 16'h0000;
    end else if (bus_read_i && half_ok) begin
      if (bus_size_i == `P9AFM_SIZE_HALF) begin
        bus_rdata_o <= sel_val;                               // [RULE2]
      end else if (dec_hi) begin
        bus_rdata_o <= {8'h00, sel_val[15:8]};                // [RULE3]
      end else begin
        bus_rdata_o <= {8'h00, sel_val[7:0]};
      end
    end else begin
      bus_rdata_o <= 16'h0000;
    end
  end

  // Pin levels come from outside the clock domain
  p9afm_sync #(
    .W     (16),
    .RESET (16'h0000)
  ) u_pin_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_s)
  );

  assign port_in_o            = pin_s;
  assign port9_mode_control_o = mode_q;

  reg [15:0] out_d;
  reg [15:0] oe_d;
  reg [18:0] per_d;
  reg [1:0]  c;

  // Routing. Prohibited codes leave the pin undriven and inputs at their idle level,
  // a safe choice although software must not rely on it [RULE20]
  always @* begin
    out_d = 16'h0000;
    oe_d  = 16'h0000;
    // Idle levels: UART receive and I2C lines rest high
    per_d = 19'h70000;
    c     = 2'h0;
    // Port I/O where the mode bit is clear [RULE1]
    out_d = port_out_i & ~mode_q;
    oe_d  = port_oe_i & ~mode_q;
    // Pin 15 [RULE9]
    c = pin_code(ext_q, func_q, 4'hF);
    if (mode_q[15]) begin
      if (c == 2'h1) per_d[0] = pin_s[15];
      if (c == 2'h2) per_d[3] = pin_s[15];
      if (c == 2'h3) {oe_d[15], out_d[15]} = {1'b1, timer50_out_i};
    end
    // Pin 14 [RULE10]
    c = pin_code(ext_q, func_q, 4'hE);
    if (mode_q[14]) begin
      if (c == 2'h1) per_d[1] = pin_s[14];
      if (c == 2'h2) per_d[4] = pin_s[14];
      if (c == 2'h3) {oe_d[14], out_d[14]} = {1'b1, timer51_out_i};
    end
    // Pins 13 to 10 [RULE11]
    if (mode_q[13] && func_q[13]) per_d[2] = pin_s[13];
    if (mode_q[12] && func_q[12])
      {out_d[12], oe_d[12], per_d[11]} = {serial3_clock_out_i, serial3_clock_oe_i, pin_s[12]};
    if (mode_q[11] && func_q[11]) {oe_d[11], out_d[11]} = {1'b1, serial3_data_out_i};
    if (mode_q[10] && func_q[10]) per_d[10] = pin_s[10];
    // Pins 9 and 8 [RULE12]
    if (mode_q[9] && func_q[9])
      {out_d[9], oe_d[9], per_d[13]} = {serial1_clock_out_i, serial1_clock_oe_i, pin_s[9]};
    if (mode_q[8] && func_q[8]) {oe_d[8], out_d[8]} = {1'b1, serial1_data_out_i};
    // Pin 7 [RULE13]
    c = pin_code(ext_q, func_q, 4'h7);
    if (mode_q[7]) begin
      if (c == 2'h1) per_d[12] = pin_s[7];
      if (c == 2'h2) per_d[5]  = pin_s[7];
      if (c == 2'h3) {oe_d[7], out_d[7]} = {1'b1, timer20_out_i};
    end
    // Pin 6 [RULE14] [RULE15]
    c = pin_code(ext_q, func_q, 4'h6);
    if (mode_q[6]) begin
      if (c == 2'h2) per_d[6] = pin_s[6];
      if (c == 2'h3) {oe_d[6], out_d[6]} = {1'b1, timer21_out_i};
    end
    // Pins 4, 3, 2: capture on 01, output on 10 [RULE14] [RULE16]
    c = pin_code(ext_q, func_q, 4'h4);
    if (mode_q[4] && c == 2'h1) per_d[7] = pin_s[4];
    if (mode_q[4] && c == 2'h2) {oe_d[4], out_d[4]} = {1'b1, timer31_out_i};
    c = pin_code(ext_q, func_q, 4'h3);
    if (mode_q[3] && c == 2'h1) per_d[8] = pin_s[3];
    if (mode_q[3] && c == 2'h2) {oe_d[3], out_d[3]} = {1'b1, timer40_out_i};
    c = pin_code(ext_q, func_q, 4'h2);
    if (mode_q[2] && c == 2'h1) per_d[9] = pin_s[2];
    if (mode_q[2] && c == 2'h2) {oe_d[2], out_d[2]} = {1'b1, timer41_out_i};
    // Pin 1: key return 7 also sees the pin in UART mode; I2C is open drain [RULE17]
    c = pin_code(ext_q, func_q, 4'h1);
    if (mode_q[1]) begin
      if (c == 2'h1 || c == 2'h2) per_d[15] = pin_s[1];
      if (c == 2'h2) per_d[16] = pin_s[1];
      if (c == 2'h3) {oe_d[1], per_d[17]} = {~i2c2_clock_line_out_i, pin_s[1]};
    end
    // Pin 0 [RULE18]
    c = pin_code(ext_q, func_q, 4'h0);
    if (mode_q[0]) begin
      if (c == 2'h1) per_d[14] = pin_s[0];
      if (c == 2'h2) {oe_d[0], out_d[0]} = {1'b1, uart1_transmit_i};
      if (c == 2'h3) {oe_d[0], per_d[18]} = {~i2c2_data_line_out_i, pin_s[0]};
    end
  end

  // Registered pin and peripheral outputs: one cycle of latency buys glitch-free pins
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out_o <= 16'h0000;
      pin_oe_o  <= 16'h0000;
      {i2c2_data_line_in_o, i2c2_clock_line_in_o, uart1_receive_o, key_return_7_o,
       key_return_6_o, serial1_clock_in_o, serial1_data_in_o, serial3_clock_in_o,
       serial3_data_in_o, timer41_capture_in_o, timer40_capture_in_o, timer31_capture_in_o,
       timer21_capture_in_o, timer20_capture_in_o, timer51_capture_in_o, timer50_capture_in_o,
       external_interrupt_4_o, external_interrupt_5_o, external_interrupt_6_o} <= 19'h70000;
    end else begin
      pin_out_o <= out_d;
      pin_oe_o  <= oe_d;
      {i2c2_data_line_in_o, i2c2_clock_line_in_o, uart1_receive_o, key_return_7_o,
       key_return_6_o, serial1_clock_in_o, serial1_data_in_o, serial3_clock_in_o,
       serial3_data_in_o, timer41_capture_in_o, timer40_capture_in_o, timer31_capture_in_o,
       timer21_capture_in_o, timer20_capture_in_o, timer51_capture_in_o, timer50_capture_in_o,
       external_interrupt_4_o, external_interrupt_5_o, external_interrupt_6_o} <= per_d;
    end
  end

endmodule

// ===== tb/p9afm_mux_chk.sv
// Concurrent checks on the register port and the port-mode pin path of the port 9 function mux
`timescale 1ns/1ps
`include "p9afm_map.vh"
module p9afm_mux_chk #(
  parameter [1:0] VARIANT = `P9AFM_VAR_LARGE
) (
  // Clock and reset
  input wire        clock_i,
  input wire        reset_n_i,
  // Register port
  input wire [31:0] bus_addr_i,
  input wire [15:0] bus_wdata_i,
  input wire        bus_write_i,
  input wire        bus_read_i,
  input wire        bus_size_i,
  input wire        bus_bit_i,
  input wire [2:0]  bus_bit_num_i,
  input wire [15:0] bus_rdata_o,
  // Pin path and mode view
  input wire [15:0] port_out_i,
  input wire [15:0] port_oe_i,
  input wire [15:0] pin_out_o,
  input wire [15:0] pin_oe_o,
  input wire [15:0] port9_mode_control_o
);
  // Implemented mode bits follow the function-control mask of the variant
  wire [15:0] mask    = (VARIANT == `P9AFM_VAR_SMALL) ? `P9AFM_CTL_MASK_SMALL :
                        (VARIANT == `P9AFM_VAR_MID) ? `P9AFM_CTL_MASK_MID : `P9AFM_CTL_MASK_LARGE;
  wire [15:0] bit_one = 16'h0001 << {bus_addr_i[0], bus_bit_num_i};
  wire [15:0] bit_exp = ((port9_mode_control_o & ~bit_one) | (bus_wdata_i[bus_bit_num_i] ? bit_one : 16'h0000)) & mask;
  wire        at_mode = (bus_addr_i == `P9AFM_MODE_ADDR);
  wire        at_hi   = (bus_addr_i == `P9AFM_MODE_HI_ADDR);

  // One clock domain, so clock and reset are given once
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  a_rdata_idle: assert property (!$past(bus_read_i) |-> bus_rdata_o == 16'h0000)
    else $error("read data not zero outside the answer cycle");
  a_fixed_zero: assert property ((port9_mode_control_o & ~mask) == 16'h0000)
    else $error("mode register holds an unimplemented bit");
  a_port_mode: assert property ((((pin_out_o ^ $past(port_out_i)) | (pin_oe_o ^ $past(port_oe_i)))
    & ~$past(port9_mode_control_o)) == 16'h0000)
    else $error("port-mode pin does not follow the port logic");
  a_full_read: assert property (bus_read_i && bus_size_i && at_mode |=>
    bus_rdata_o == $past(port9_mode_control_o))
    else $error("halfword mode read returned wrong data");
  a_hi_read: assert property (bus_read_i && !bus_size_i && at_hi |=>
    bus_rdata_o == {8'h00, $past(port9_mode_control_o[15:8])})
    else $error("high view read is not register bits 15 to 8");
  a_full_write: assert property (bus_write_i && bus_size_i && at_mode |=>
    port9_mode_control_o == ($past(bus_wdata_i) & mask))
    else $error("halfword mode write not stored");
  a_hi_write: assert property (bus_write_i && !bus_size_i && !bus_bit_i && at_hi |=>
    port9_mode_control_o == {$past(bus_wdata_i[7:0]) & mask[15:8], $past(port9_mode_control_o[7:0])})
    else $error("high view byte write misplaced");
  a_bit_write: assert property (bus_write_i && bus_bit_i && (at_mode || at_hi) |=>
    port9_mode_control_o == $past(bit_exp))
    else $error("single-bit mode write touched the wrong bit");
endmodule
bind p9afm_mux p9afm_mux_chk #(.VARIANT(VARIANT)) chk_u (.clock_i, .reset_n_i, .bus_addr_i, .bus_wdata_i,
  .bus_write_i, .bus_read_i, .bus_size_i, .bus_bit_i, .bus_bit_num_i, .bus_rdata_o, .port_out_i, .port_oe_i,
  .pin_out_o, .pin_oe_o, .port9_mode_control_o);

// ===== tb/p9afm_far.sv
// Far-side model: package pins shared by the device and an external source
`timescale 1ns/1ps
module p9afm_far (
  // Device pin drive
  input  wire [15:0] pin_out_i,
  input  wire [15:0] pin_oe_i,
  // External source level
  input  wire [15:0] ext_lvl_i,
  // Resolved pin level
  output wire [15:0] pin_lvl_o
);
  // External source yields wherever the device drives, so no line is ever contested
  assign pin_lvl_o = (pin_out_i & pin_oe_i) | (ext_lvl_i & ~pin_oe_i);
endmodule

// ===== tb/test_p9afm_mux.sv
// Self-checking bench for the port 9 function mux: registers, views and pin routing
`timescale 1ns/1ps
`include "p9afm_map.vh"
module test_p9afm_mux;
  // Clock, reset and bus drive
  reg         clk;
  reg         rst_n;
  reg  [31:0] addr_q;
  reg  [15:0] wdata_q;
  reg         wr_q;
  reg         rd_q;
  reg         size_q;
  reg         bit_q;
  reg  [2:0]  bnum_q;
  // Port logic, peripheral outputs and external pin source
  reg  [15:0] pout_q;
  reg  [15:0] poe_q;
  reg  [15:0] per_q;
  reg  [15:0] ext_q;
  // Observed outputs
  wire [15:0] rdata;
  wire [15:0] pin_out;
  wire [15:0] pin_oe;
  wire [15:0] pin_lvl;
  wire [15:0] port_in;
  wire [15:0] mode;
  wire [18:0] fn_in;
  integer     error_cnt;
  integer     tests_run;

  // Device under test, peripheral inputs gathered into one vector
  p9afm_mux dut_u (.clock_i(clk), .reset_n_i(rst_n), .bus_addr_i(addr_q), .bus_wdata_i(wdata_q),
    .bus_write_i(wr_q), .bus_read_i(rd_q), .bus_size_i(size_q), .bus_bit_i(bit_q), .bus_bit_num_i(bnum_q),
    .bus_rdata_o(rdata), .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .port_out_i(pout_q),
    .port_oe_i(poe_q), .port_in_o(port_in), .port9_mode_control_o(mode),
    .external_interrupt_6_o(fn_in[0]), .external_interrupt_5_o(fn_in[1]), .external_interrupt_4_o(fn_in[2]),
    .timer50_capture_in_o(fn_in[3]), .timer51_capture_in_o(fn_in[4]), .timer20_capture_in_o(fn_in[5]),
    .timer21_capture_in_o(fn_in[6]), .timer31_capture_in_o(fn_in[7]), .timer40_capture_in_o(fn_in[8]),
    .timer41_capture_in_o(fn_in[9]), .serial3_data_in_o(fn_in[10]), .serial3_clock_in_o(fn_in[11]),
    .serial1_data_in_o(fn_in[12]), .serial1_clock_in_o(fn_in[13]), .key_return_6_o(fn_in[14]),
    .key_return_7_o(fn_in[15]), .uart1_receive_o(fn_in[16]), .i2c2_clock_line_in_o(fn_in[17]),
    .i2c2_data_line_in_o(fn_in[18]), .timer50_out_i(per_q[0]), .timer51_out_i(per_q[1]),
    .timer20_out_i(per_q[2]), .timer21_out_i(per_q[3]), .timer31_out_i(per_q[4]), .timer40_out_i(per_q[5]),
    .timer41_out_i(per_q[6]), .serial3_clock_out_i(per_q[7]), .serial3_clock_oe_i(per_q[8]),
    .serial3_data_out_i(per_q[9]), .serial1_clock_out_i(per_q[10]), .serial1_clock_oe_i(per_q[11]),
    .serial1_data_out_i(per_q[12]), .uart1_transmit_i(per_q[13]), .i2c2_clock_line_out_i(per_q[14]),
    .i2c2_data_line_out_i(per_q[15]));
  p9afm_far far_u (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_lvl_i(ext_q), .pin_lvl_o(pin_lvl));

  // 200 MHz system clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task check(input string what, input [15:0] exp, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // One strobe cycle; returns once read data stand
  task bus(input w, input [31:0] a, input [15:0] d, input sz, input bt, input [2:0] bn);
    begin
      @(posedge clk);
      addr_q <= a;
      wdata_q <= d;
      size_q <= sz;
      bit_q <= bt;
      bnum_q <= bn;
      wr_q <= w;
      rd_q <= !w;
      @(posedge clk);
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      #1;
    end
  endtask

  task wr16(input [31:0] a, input [15:0] d);
    bus(1'h1, a, d, 1'h1, 1'h0, 3'h0);
  endtask

  task wr8(input [31:0] a, input [15:0] d);
    bus(1'h1, a, d, 1'h0, 1'h0, 3'h0);
  endtask

  task wrb(input [31:0] a, input [2:0] n, input [15:0] d);
    bus(1'h1, a, d, 1'h0, 1'h1, n);
  endtask

  task rd(input [31:0] a, input sz, input [15:0] exp, input string what);
    begin
      bus(1'h0, a, 16'h0000, sz, 1'h0, 3'h0);
      check(what, exp, rdata);
    end
  endtask

  task s_masks;
    begin
      rd(`P9AFM_FUNC_ADDR, 1'h1, `P9AFM_FUNC_RESET, "function reset");
      rd(`P9AFM_EXT_ADDR, 1'h1, `P9AFM_EXT_RESET, "extension reset");
      wr16(`P9AFM_FUNC_ADDR, 16'h0000);
      wr16(`P9AFM_EXT_ADDR, 16'h0000);
      wr16(`P9AFM_MODE_ADDR, 16'hFFFF);
      rd(`P9AFM_MODE_ADDR, 1'h1, `P9AFM_CTL_MASK_LARGE, "mode all pins");
      wr16(`P9AFM_MODE_ADDR, 16'h0000);
      wr16(`P9AFM_FUNC_ADDR, 16'hFFFF);
      wr16(`P9AFM_EXT_ADDR, 16'hFFFF);
      rd(`P9AFM_FUNC_ADDR, 1'h1, `P9AFM_CTL_MASK_LARGE, "function bits");
      rd(`P9AFM_EXT_ADDR, 1'h1, `P9AFM_EXT_MASK_LARGE, "extension bits");
      rd(`P9AFM_EXT_HI_ADDR, 1'h0, 16'h00C0, "extension high view");
      rd(32'hFFFFF470, 1'h1, 16'h0000, "unmapped read");
    end
  endtask

  // Byte views, single bits and a refused halfword at the odd address
  task s_alias(input [31:0] b, input string nm);
    begin
      wr8(b, 16'h003C);
      wr8(b + 32'h1, 16'h00A5);
      rd(b, 1'h1, 16'hA51C, nm);
      rd(b + 32'h1, 1'h0, 16'h00A5, nm);
      rd(b, 1'h0, 16'h001C, nm);
      wrb(b + 32'h1, 3'h7, 16'h0000);
      wrb(b, 3'h5, 16'h0020);
      wrb(b, 3'h1, 16'h0002);
      rd(b, 1'h1, 16'h251E, nm);
      bus(1'h1, b + 32'h1, 16'hFFFF, 1'h1, 1'h0, 3'h0);
      rd(b, 1'h1, 16'h251E, nm);
    end
  endtask

  task s_port_mode;
    begin
      wr16(`P9AFM_MODE_ADDR, 16'h0000);
      @(posedge clk);
      pout_q <= 16'hA5C3;
      poe_q <= 16'h0F0F;
      ext_q <= 16'h5A3C;
      repeat (6) @(posedge clk);
      #1;
      check("port drive", 16'hA5C3, pin_out);
      check("port enable", 16'h0F0F, pin_oe);
      check("port input", (16'hA5C3 & 16'h0F0F) | (16'h5A3C & ~16'h0F0F), port_in);
    end
  endtask

  // Kind 0 drives the pin, 1 feeds a peripheral input, 2 is open drain; other lines carry the inverse, except kind 1 holds peripheral outputs at C000
  task route(input [3:0] p, input [1:0] c, input [1:0] k, input [4:0] x);
    integer v;
    begin
      wr16(`P9AFM_MODE_ADDR, 16'h0000);
      wr16(`P9AFM_EXT_ADDR, {15'h0000, c[1]} << p);
      wr16(`P9AFM_FUNC_ADDR, {15'h0000, c[0]} << p);
      wr16(`P9AFM_MODE_ADDR, 16'h0001 << p);
      for (v = 0; v < 2; v = v + 1) begin
        @(posedge clk);
        per_q <= (k == 2'h1) ? 16'hC000 : (v[0] ? 16'h0001 << x : ~(16'h0001 << x));
        ext_q <= v[0] ? 16'h0001 << p : ~(16'h0001 << p);
        repeat (6) @(posedge clk);
        #1;
        if (k == 2'h1)
          check("peripheral input", {15'h0000, v[0]}, {15'h0000, fn_in[x]});
        else
          check("pin drive", (k == 2'h2) ? {14'h0000, !v[0], 1'h0} : {14'h0000, 1'h1, v[0]},
                {14'h0000, pin_oe[p], pin_out[p]});
      end
    end
  endtask

  task results;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_n = 1'h0;
    {addr_q, wdata_q, wr_q, rd_q, size_q, bit_q, bnum_q} = 55'h0;
    {pout_q, poe_q, per_q, ext_q} = 64'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    s_masks;
    s_alias(`P9AFM_FUNC_ADDR, "function views");
    wr16(`P9AFM_FUNC_ADDR, 16'hFFDF);
    wr16(`P9AFM_EXT_ADDR, 16'h0040);
    s_alias(`P9AFM_MODE_ADDR, "mode views");
    s_port_mode;
    route(4'hF, 2'h3, 2'h0, 5'h00);
    route(4'hF, 2'h1, 2'h1, 5'h00);
    route(4'hF, 2'h2, 2'h1, 5'h03);
    route(4'hE, 2'h3, 2'h0, 5'h01);
    route(4'hE, 2'h1, 2'h1, 5'h01);
    route(4'hE, 2'h2, 2'h1, 5'h04);
    route(4'hD, 2'h1, 2'h1, 5'h02);
    route(4'hC, 2'h1, 2'h1, 5'h0B);
    route(4'hB, 2'h1, 2'h0, 5'h09);
    route(4'hA, 2'h1, 2'h1, 5'h0A);
    route(4'h9, 2'h1, 2'h1, 5'h0D);
    route(4'h8, 2'h1, 2'h0, 5'h0C);
    route(4'h7, 2'h3, 2'h0, 5'h02);
    route(4'h7, 2'h1, 2'h1, 5'h0C);
    route(4'h7, 2'h2, 2'h1, 5'h05);
    route(4'h6, 2'h3, 2'h0, 5'h03);
    route(4'h6, 2'h2, 2'h1, 5'h06);
    route(4'h4, 2'h2, 2'h0, 5'h04);
    route(4'h4, 2'h1, 2'h1, 5'h07);
    route(4'h3, 2'h2, 2'h0, 5'h05);
    route(4'h3, 2'h1, 2'h1, 5'h08);
    route(4'h2, 2'h2, 2'h0, 5'h06);
    route(4'h2, 2'h1, 2'h1, 5'h09);
    route(4'h1, 2'h1, 2'h1, 5'h0F);
    route(4'h1, 2'h2, 2'h1, 5'h10);
    route(4'h1, 2'h3, 2'h1, 5'h11);
    route(4'h1, 2'h3, 2'h2, 5'h0E);
    route(4'h0, 2'h1, 2'h1, 5'h0E);
    route(4'h0, 2'h2, 2'h0, 5'h0D);
    route(4'h0, 2'h3, 2'h1, 5'h12);
    route(4'h0, 2'h3, 2'h2, 5'h0F);
    results;
  end
endmodule
